// >>> design/host_ec_mailbox_window.v
/*
  host/controller mailbox pair plus memory window address, access type and
  data register that drive a simple internal memory port.
  assumes host and controller ports are synchronous to core_clk_in and the
  memory answers reads with mem_ack_in in a later cycle.
*/
// Notes on behaviour
// - host write to inbound mailbox stores byte and notifies controller
// - controller may clear any inbound bits; host reads the result
// - controller write to outbound mailbox stores byte and notifies host
// - host write-one clears outbound bits; remaining bits stay readable
// - host and controller views share one storage per mailbox
// - low register bits 7:2 give offset bits 7:2; bits 1:0 read back the access type
// - access type 11 auto32, 10 32-bit, 01 16-bit, 00 8-bit
// - high register bits 6:0 give offset bits 14:8
// - high register bit 7 selects base 1 or base 0
// - memory address is selected base plus offset bits 14:2, plus the byte lane in 8-bit mode
// - auto-increment: byte 3 access advances offset one dword afterwards
// - 32-bit: byte 0 read loads dword; byte 3 write commits dword
// - 16-bit: byte 0/2 reads load halfword; byte 1/3 writes commit
// - 8-bit: each byte read fetches, each byte write updates memory
`timescale 1ns/10ps
`include "mailbox_window_map.vh"

module host_ec_mailbox_window (
  // clock and reset
  input  wire        core_clk_in,
  input  wire        reset_in,
  // host register port
  input  wire        host_req_in,
  input  wire        host_wr_in,
  input  wire [2:0]  host_addr_in,
  input  wire [7:0]  host_wdata_in,
  output wire        host_ready_out,
  output reg  [7:0]  host_rdata_out,
  output reg         host_rvalid_out,
  // controller port
  input  wire        ctl_inbound_clr_in,
  input  wire [7:0]  ctl_inbound_clr_mask_in,
  input  wire        ctl_outbound_wr_in,
  input  wire [7:0]  ctl_outbound_wdata_in,
  input  wire        ctl_inbound_ack_in,
  input  wire        host_outbound_ack_in,
  output wire [7:0]  inbound_message_byte_out,
  output wire [7:0]  outbound_message_byte_out,
  output wire        ctl_notify_out,
  output wire        host_notify_out,
  // segment bases
  input  wire [31:0] base0_in,
  input  wire [31:0] base1_in,
  // internal memory port
  output reg         mem_req_out,
  output reg         mem_wr_out,
  output reg  [31:0] mem_addr_out,
  output reg  [31:0] mem_wdata_out,
  output reg  [3:0]  mem_be_out,
  input  wire        mem_ack_in,
  input  wire [31:0] mem_rdata_in
);

  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_WAIT = 2'b10;

  reg  [7:0]  inbound_q;
  reg  [7:0]  outbound_q;
  reg         ctl_pend_q;
  reg         host_pend_q;
  reg  [5:0]  addr_low_q;
  reg  [1:0]  acc_type_q;
  reg  [6:0]  addr_high_q;
  reg         segment_q;
  reg  [31:0] data_q;
  reg  [1:0]  state_q;
  reg         rd_pend_q;
  reg  [1:0]  rd_byte_q;
  reg         inc_pend_q;
  reg  [3:0]  fetch_be_q;

  wire        take;
  wire        hwr;
  wire        hrd;
  wire        data_sel;
  wire [1:0]  bsel;
  wire [12:0] dword_off;
  wire [31:0] win_addr;
  wire [31:0] wr_word;
  reg         do_mem;
  reg         mem_is_wr;
  reg  [3:0]  be;
  reg  [1:0]  addr_byte;

  // byte enable mask for one lane
  function [3:0] lane_mask;
    input [1:0] b;
    begin
      lane_mask = 4'h1 << b;
    end
  endfunction

  // select one byte from a word
  function [7:0] pick_byte;
    input [31:0] w;
    input [1:0]  b;
    begin
      pick_byte = w[8*b +: 8];
    end
  endfunction

  // widen a 4-bit byte mask to 32 bits
  function [31:0] byte_bits;
    input [3:0] m;
    begin
      byte_bits = {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
    end
  endfunction

  assign host_ready_out = (state_q == ST_IDLE);
  assign take     = host_req_in & host_ready_out;
  assign hwr      = take & host_wr_in;
  assign hrd      = take & ~host_wr_in;
  assign data_sel = host_addr_in[2];
  assign bsel     = host_addr_in[1:0];
  assign dword_off = {addr_high_q, addr_low_q};
  assign wr_word  = {data_q[31:0]};
  assign inbound_message_byte_out  = inbound_q;
  assign outbound_message_byte_out = outbound_q;
  assign ctl_notify_out  = ctl_pend_q;
  assign host_notify_out = host_pend_q;

  window_address_gen u_addr (
    .dword_offset_in (dword_off),
    .segment_sel_in  (segment_q),
    .byte_sel_in     (addr_byte),
    .base0_in        (base0_in),
    .base1_in        (base1_in),
    .mem_addr_out    (win_addr)
  );

  // decode which data accesses touch memory
  always @* begin
    do_mem    = 1'b0;
    mem_is_wr = 1'b0;
    be        = 4'h0;
    addr_byte = 2'h0;
    if (take && data_sel) begin
      case (acc_type_q)
        `ACC_AUTO32, `ACC_32: begin
          if (!host_wr_in && bsel == 2'h0) begin
            do_mem = 1'b1;
            be     = 4'hF;
          end else if (host_wr_in && bsel == 2'h3) begin
            do_mem    = 1'b1;
            mem_is_wr = 1'b1;
            be        = 4'hF;
          end
        end
        `ACC_16: begin
          if ((!host_wr_in && !bsel[0]) || (host_wr_in && bsel[0])) begin
            do_mem    = 1'b1;
            mem_is_wr = host_wr_in;
            be        = bsel[1] ? 4'hC : 4'h3;
          end
        end
        default: begin
          do_mem    = 1'b1;
          mem_is_wr = host_wr_in;
          be        = lane_mask(bsel);
          addr_byte = bsel;
        end
      endcase
    end
  end

  always @(posedge core_clk_in) begin
    if (reset_in) begin
      inbound_q       <= `RESET_BYTE;
      outbound_q      <= `RESET_BYTE;
      ctl_pend_q      <= 1'b0;
      host_pend_q     <= 1'b0;
      addr_low_q      <= 6'h00;
      acc_type_q      <= `ACC_8;
      addr_high_q     <= 7'h00;
      segment_q       <= 1'b0;
      data_q          <= `RESET_WORD;
      state_q         <= ST_IDLE;
      rd_pend_q       <= 1'b0;
      rd_byte_q       <= 2'h0;
      inc_pend_q      <= 1'b0;
      fetch_be_q      <= 4'h0;
      host_rdata_out  <= `RESET_BYTE;
      host_rvalid_out <= 1'b0;
      mem_req_out     <= 1'b0;
      mem_wr_out      <= 1'b0;
      mem_addr_out    <= `RESET_WORD;
      mem_wdata_out   <= `RESET_WORD;
      mem_be_out      <= 4'h0;
    end else begin
      host_rvalid_out <= 1'b0;
      // inbound mailbox: host write wins over a same-cycle controller clear
      if (hwr && host_addr_in == `OFS_INBOUND_MBOX)
        inbound_q <= host_wdata_in;
      else if (ctl_inbound_clr_in)
        inbound_q <= inbound_q & ~ctl_inbound_clr_mask_in;
      // outbound mailbox: controller write wins over host clear
      if (ctl_outbound_wr_in)
        outbound_q <= ctl_outbound_wdata_in;
      else if (hwr && host_addr_in == `OFS_OUTBOUND_MBOX)
        outbound_q <= outbound_q & ~host_wdata_in;
      // sticky notifications, set beats acknowledge
      if (hwr && host_addr_in == `OFS_INBOUND_MBOX)
        ctl_pend_q <= 1'b1;
      else if (ctl_inbound_ack_in)
        ctl_pend_q <= 1'b0;
      if (ctl_outbound_wr_in)
        host_pend_q <= 1'b1;
      else if (host_outbound_ack_in)
        host_pend_q <= 1'b0;
      // window registers
      if (hwr && host_addr_in == `OFS_ADDR_LOW) begin
        addr_low_q <= host_wdata_in[7:2];
        acc_type_q <= host_wdata_in[1:0];
      end
      if (hwr && host_addr_in == `OFS_ADDR_HIGH) begin
        segment_q   <= host_wdata_in[`SEGMENT_BIT];
        addr_high_q <= host_wdata_in[6:0];
      end
      // data register writes land in the register immediately
      if (hwr && data_sel)
        data_q[8*bsel +: 8] <= host_wdata_in;
      // register reads answer next cycle unless memory must be fetched
      if (hrd && !(do_mem && !mem_is_wr)) begin
        host_rvalid_out <= 1'b1;
        case (host_addr_in)
          `OFS_INBOUND_MBOX:  host_rdata_out <= inbound_q;
          `OFS_OUTBOUND_MBOX: host_rdata_out <= outbound_q;
          `OFS_ADDR_LOW:      host_rdata_out <= {addr_low_q, acc_type_q};
          `OFS_ADDR_HIGH:     host_rdata_out <= {segment_q, addr_high_q};
          default:            host_rdata_out <= pick_byte(data_q, bsel);
        endcase
      end
      case (state_q)
        ST_IDLE: begin
          if (do_mem) begin
            mem_req_out   <= 1'b1;
            mem_wr_out    <= mem_is_wr;
            mem_addr_out  <= win_addr;
            mem_be_out    <= be;
            // written byte is not in data_q yet, so merge it into its own lane only
            mem_wdata_out <= host_wr_in ? (({4{host_wdata_in}} & byte_bits(lane_mask(bsel))) |
                             (wr_word & ~byte_bits(lane_mask(bsel)))) : wr_word;
            rd_pend_q     <= ~mem_is_wr;
            rd_byte_q     <= bsel;
            fetch_be_q    <= be;
            state_q       <= ST_WAIT;
          end
          if (take && data_sel && bsel == 2'h3 && acc_type_q == `ACC_AUTO32) begin
            if (do_mem)
              inc_pend_q <= 1'b1;
            else
              {addr_high_q, addr_low_q} <= dword_off + `DWORD_STEP;
          end
        end
        ST_WAIT: begin
          if (mem_ack_in) begin
            mem_req_out <= 1'b0;
            state_q     <= ST_IDLE;
            if (rd_pend_q) begin
              data_q <= (data_q & ~byte_bits(fetch_be_q)) |
                        (mem_rdata_in & byte_bits(fetch_be_q));
              host_rdata_out  <= pick_byte(mem_rdata_in, rd_byte_q);
              host_rvalid_out <= 1'b1;
            end
            if (inc_pend_q) begin
              inc_pend_q <= 1'b0;
              {addr_high_q, addr_low_q} <= dword_off + `DWORD_STEP;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

endmodule // host_ec_mailbox_window

// >>> design/mailbox_window_map.vh
/*
  register offsets, field positions, reset values and access-type codes
  for the host/controller mailbox and memory window block.
  assumes inclusion by bare name from design files.
*/
`ifndef MAILBOX_WINDOW_MAP_VH
`define MAILBOX_WINDOW_MAP_VH

`define OFS_INBOUND_MBOX      3'h0
`define OFS_OUTBOUND_MBOX     3'h1
`define OFS_ADDR_LOW          3'h2
`define OFS_ADDR_HIGH         3'h3
`define OFS_DATA_BYTE0        3'h4
`define OFS_DATA_BYTE1        3'h5
`define OFS_DATA_BYTE2        3'h6
`define OFS_DATA_BYTE3        3'h7

`define RESET_BYTE            8'h00
`define RESET_WORD            32'h0000_0000

`define ACC_AUTO32            2'h3
`define ACC_32                2'h2
`define ACC_16                2'h1
`define ACC_8                 2'h0

`define SEGMENT_BIT           7
`define DWORD_STEP            13'h0001

`endif

// >>> design/window_address_gen.v
/*
  window address generator: forms the 32-bit internal address from the
  selected segment base plus the dword window offset and byte select.
  assumes base addresses are stable from the controller side.
*/
`timescale 1ns/10ps
`include "mailbox_window_map.vh"

module window_address_gen (
  // window state
  input  wire [12:0] dword_offset_in,
  input  wire        segment_sel_in,
  input  wire [1:0]  byte_sel_in,
  // segment bases
  input  wire [31:0] base0_in,
  input  wire [31:0] base1_in,
  // result
  output wire [31:0] mem_addr_out
);

  wire [31:0] base_sel;
  wire [31:0] offset_ext;

  assign base_sel     = segment_sel_in ? base1_in : base0_in;
  assign offset_ext   = {17'h00000, dword_offset_in, byte_sel_in};
  assign mem_addr_out = base_sel + offset_ext;

endmodule // window_address_gen

// >>> test/host_ec_mailbox_window_asserts.sv
/* checker for mailbox, notify and memory port timing.
   assumes bind into host_ec_mailbox_window. */
`timescale 1ns/10ps
module mailbox_window_checker (
  input wire        core_clk_in,
  input wire        reset_in,
  input wire        host_req_in,
  input wire        host_wr_in,
  input wire [2:0]  host_addr_in,
  input wire [7:0]  host_wdata_in,
  input wire        host_ready_out,
  input wire [7:0]  host_rdata_out,
  input wire        host_rvalid_out,
  input wire        ctl_inbound_clr_in,
  input wire [7:0]  ctl_inbound_clr_mask_in,
  input wire        ctl_outbound_wr_in,
  input wire [7:0]  ctl_outbound_wdata_in,
  input wire        ctl_inbound_ack_in,
  input wire [7:0]  inbound_message_byte_out,
  input wire [7:0]  outbound_message_byte_out,
  input wire        ctl_notify_out,
  input wire        host_notify_out,
  input wire        mem_req_out,
  input wire [31:0] mem_addr_out,
  input wire        mem_ack_in
);
  wire tk  = host_req_in & host_ready_out;
  wire hw0 = tk & host_wr_in & (host_addr_in == 3'h0);
  wire hw1 = tk & host_wr_in & (host_addr_in == 3'h1);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  a_inbound_store: assert property (
    hw0 |=> ctl_notify_out && inbound_message_byte_out == $past(host_wdata_in))
    else $error("inbound store failed");
  a_inbound_clear: assert property (
    ctl_inbound_clr_in && !hw0 |=> inbound_message_byte_out ==
      ($past(inbound_message_byte_out) & ~$past(ctl_inbound_clr_mask_in)))
    else $error("inbound clear failed");
  a_outbound_store: assert property (
    ctl_outbound_wr_in |=> host_notify_out &&
      outbound_message_byte_out == $past(ctl_outbound_wdata_in))
    else $error("outbound store failed");
  a_outbound_wclear: assert property (
    hw1 && !ctl_outbound_wr_in |=> outbound_message_byte_out ==
      ($past(outbound_message_byte_out) & ~$past(host_wdata_in)))
    else $error("outbound clear failed");
  a_notify_held: assert property (
    ctl_notify_out && !ctl_inbound_ack_in |=> ctl_notify_out)
    else $error("notify dropped");
  a_inbound_read: assert property (
    tk && !host_wr_in && host_addr_in == 3'h0 |=> host_rvalid_out &&
      host_rdata_out == $past(inbound_message_byte_out))
    else $error("inbound read wrong");
  a_mem_hold: assert property (
    mem_req_out && !mem_ack_in |=> mem_req_out && $stable(mem_addr_out))
    else $error("memory request moved");
  a_mem_release: assert property (
    mem_req_out && mem_ack_in |=> !mem_req_out && host_ready_out)
    else $error("memory request not released");
  c_inbound: cover property (hw0);
  c_mem_done: cover property (mem_req_out && mem_ack_in);
  c_outbound: cover property (ctl_outbound_wr_in);
endmodule // mailbox_window_checker

bind host_ec_mailbox_window mailbox_window_checker u_mailbox_window_checker (.*);

// >>> test/mem_model.sv
/* byte-wide sparse memory answering the internal memory port.
   assumes one request at a time, held until ack. */
`timescale 1ns/10ps
module mem_model (
  input  wire        clk_in,
  input  wire        req_in,
  input  wire        wr_in,
  input  wire [31:0] addr_in,
  input  wire [31:0] wdata_in,
  input  wire [3:0]  be_in,
  output reg         ack_out,
  output reg  [31:0] rdata_out
);
  reg [7:0] mem [bit [31:0]];
  bit [31:0] a;
  integer i;
  initial begin
    ack_out = 1'b0;
    rdata_out = 32'h0;
    forever begin
      @(posedge clk_in);
      // look at the request once the launching edge has settled
      #1;
      if (req_in) begin
        repeat ($urandom % 3) @(posedge clk_in);
        #1;
        for (i = 0; i < 4; i++) begin
          a = {addr_in[31:2], 2'b00} + i;
          if (wr_in && be_in[i]) mem[a] = wdata_in[8*i +: 8];
          rdata_out[8*i +: 8] = mem.exists(a) ? mem[a] : 8'h00;
        end
        ack_out = 1'b1;
        @(posedge clk_in);
        #1;
        ack_out = 1'b0;
        // read data not held past ack
        rdata_out = ~rdata_out;
      end
    end
  end
endmodule // mem_model

// >>> test/test_host_ec_mailbox_window.sv
/* self-checking bench with a reference model of mailboxes and window.
   assumes mem_model answers the memory port. */
`timescale 1ns/10ps
module test_host_ec_mailbox_window;
  logic        core_clk_in, reset_in, host_req_in, host_wr_in, host_ready_out, host_rvalid_out;
  logic [2:0]  host_addr_in;
  logic [7:0]  host_wdata_in, host_rdata_out, ctl_inbound_clr_mask_in, ctl_outbound_wdata_in;
  logic        ctl_inbound_clr_in, ctl_outbound_wr_in, ctl_inbound_ack_in, host_outbound_ack_in;
  logic [7:0]  inbound_message_byte_out, outbound_message_byte_out, rd, v, m;
  logic        ctl_notify_out, host_notify_out, mem_req_out, mem_wr_out, mem_ack_in, seg;
  logic [31:0] base0_in, base1_in, mem_addr_out, mem_wdata_out, mem_rdata_in, dreg;
  logic [3:0]  mem_be_out;
  logic [12:0] off;
  logic [1:0]  mode;
  logic [35:0] mgot;
  logic [7:0]  rmem [bit [31:0]];
  bit          mseen;
  int          failures, cmp_count, k;

  host_ec_mailbox_window u_host_ec_mailbox_window (.*);
  mem_model u_mem_model (.clk_in(core_clk_in), .req_in(mem_req_out), .wr_in(mem_wr_out),
    .addr_in(mem_addr_out), .wdata_in(mem_wdata_out), .be_in(mem_be_out),
    .ack_out(mem_ack_in), .rdata_out(mem_rdata_in));

  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  always @(posedge core_clk_in) if (mem_req_out) begin
    mseen <= 1'b1;
    mgot <= {mem_be_out, mem_addr_out};
  end

  task test_done;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk_mem(input logic [35:0] e, input logic [35:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("mismatch t=%0t exp %h got %h", $time, e, g);
    end
  endtask
  task chk_byte(input logic [7:0] e, input logic [7:0] g);
    chk_mem({28'h0, e}, {28'h0, g});
  endtask
  task host(input bit wr, input logic [2:0] a, input logic [7:0] d);
    int n;
    {host_req_in, host_wr_in, host_addr_in, host_wdata_in} = {1'b1, wr, a, d};
    @(posedge core_clk_in);
    #1;
    host_req_in = 1'b0;
    n = 0;
    while (!wr && host_rvalid_out !== 1'b1 && n < 60) begin
      @(posedge core_clk_in);
      #1;
      n++;
    end
    rd = host_rdata_out;
    while (host_ready_out !== 1'b1 && n < 60) begin
      @(posedge core_clk_in);
      #1;
      n++;
    end
    if (n == 60) failures++;
    // idle edge so a following call never re-raises the request in the same step
    @(posedge core_clk_in);
    #1;
  endtask
  // c: 0 inbound clear, 1 outbound write, 2 inbound ack, 3 outbound ack
  task ctl(input int c, input logic [7:0] d);
    ctl_inbound_clr_mask_in = d;
    ctl_outbound_wdata_in = d;
    {ctl_inbound_clr_in, ctl_outbound_wr_in, ctl_inbound_ack_in, host_outbound_ack_in} = 4'h8 >> c;
    @(posedge core_clk_in);
    #1;
    {ctl_inbound_clr_in, ctl_outbound_wr_in, ctl_inbound_ack_in, host_outbound_ack_in} = 4'h0;
    @(posedge core_clk_in);
    #1;
  endtask
  task acc(input bit wr, input int l, input logic [7:0] d);
    logic [31:0] a, b;
    logic [3:0] be;
    bit hit;
    a = (seg ? base1_in : base0_in) + {off, 2'b00} + ((mode == 2'h0) ? l : 0);
    hit = mode == 2'h0 || (mode[1] ? (wr ? l == 3 : l == 0) : (wr ? l[0] : !l[0]));
    be = (mode == 2'h0) ? 4'h1 << l : mode[1] ? 4'hF : (l > 1 ? 4'hC : 4'h3);
    if (wr) dreg[8*l +: 8] = d;
    if (hit) for (int i = 0; i < 4; i++) if (be[i]) begin
      b = {a[31:2], 2'b00} + i;
      if (wr) rmem[b] = dreg[8*i +: 8];
      else dreg[8*i +: 8] = rmem.exists(b) ? rmem[b] : 8'h00;
    end
    mseen = 1'b0;
    host(wr, 3'h4 + 3'(l), d);
    chk_mem(hit ? {be, a} : 36'h0, mseen ? mgot : 36'h0);
    if (!wr) chk_byte(dreg[8*l +: 8], rd);
    if (mode == 2'h3 && l == 3) off++;
  endtask

  initial begin
    failures = 0;
    cmp_count = 0;
    dreg = 32'h0;
    k = $urandom(28960);
    reset_in = 1'b1;
    {host_req_in, host_wr_in, host_addr_in, host_wdata_in} = 13'h0;
    base0_in = $urandom & 32'hFFFF_FFFC;
    base1_in = $urandom & 32'hFFFF_FFFC;
    ctl(4, 8'h00);
    repeat (8) @(posedge core_clk_in);
    #1 reset_in = 1'b0;
    for (k = 0; k < 8; k++) begin
      host(1'b0, 3'(k), 8'h00);
      chk_byte(8'h00, rd);
    end
    $display("test reset values done");
    v = $urandom;
    m = $urandom;
    host(1'b1, 3'h0, v);
    chk_mem({28'h1, v}, {27'h0, ctl_notify_out, inbound_message_byte_out});
    ctl(2, 8'h00);
    ctl(0, m);
    host(1'b0, 3'h0, 8'h00);
    chk_mem({28'h0, v & ~m}, {27'h0, ctl_notify_out, rd});
    ctl(1, v);
    chk_mem({28'h1, v}, {27'h0, host_notify_out, outbound_message_byte_out});
    host(1'b1, 3'h1, m);
    host(1'b0, 3'h1, 8'h00);
    chk_byte(v & ~m, rd);
    ctl(3, 8'h00);
    chk_byte({7'h0, host_notify_out}, 8'h00);
    $display("test mailboxes done");
    for (k = 0; k < 4; k++) begin
      mode = 2'(k);
      seg = $urandom;
      off = 13'($urandom);
      host(1'b1, 3'h2, {off[5:0], mode});
      host(1'b1, 3'h3, {seg, off[12:6]});
      repeat (12) acc($urandom, $urandom % 4, $urandom);
      host(1'b0, 3'h2, 8'h00);
      chk_byte({off[5:0], mode}, rd);
      host(1'b0, 3'h3, 8'h00);
      chk_byte({seg, off[12:6]}, rd);
      $display("test mode %0d done", k);
    end
    host(1'b1, 3'h0, 8'hA5);
    ctl(1, 8'h5A);
    reset_in = 1'b1;
    repeat (2) @(posedge core_clk_in);
    #1 reset_in = 1'b0;
    chk_mem(36'h0, {34'h0, ctl_notify_out, host_notify_out});
    for (k = 0; k < 4; k++) begin
      host(1'b0, 3'(k), 8'h00);
      chk_byte(8'h00, rd);
    end
    $display("test mid-run reset done");
    test_done;
  end
  initial begin
    #100000;
    failures++;
    test_done;
  end
endmodule // test_host_ec_mailbox_window
